// File: inc/mci_pkg.sv
// Shared constants and carrier types of the multicast ingress classifier.
// Assumes a 32-bit APB register window and one TLP header per clock.
package mci_pkg;
   // Group limits; counts are held as number of groups minus one
   localparam int         GRP_MAX   = 64;
   localparam logic [5:0] CAP_RST   = 6'h1f;
   localparam logic [5:0] CAP_LIMIT = 6'h3f;
   // Register byte offsets
   localparam logic [7:0] A_CAP     = 8'h00;
   localparam logic [7:0] A_CTRL    = 8'h04;
   localparam logic [7:0] A_BASE_LO = 8'h08;
   localparam logic [7:0] A_BASE_HI = 8'h0c;
   localparam logic [7:0] A_DALL_LO = 8'h10;
   localparam logic [7:0] A_DALL_HI = 8'h14;
   localparam logic [7:0] A_DRAW_LO = 8'h18;
   localparam logic [7:0] A_DRAW_HI = 8'h1c;
   localparam logic [7:0] A_STAT    = 8'h20;
   localparam logic [7:0] A_LOG0    = 8'h24;
   localparam logic [7:0] A_LOG1    = 8'h28;
   localparam logic [7:0] A_LOG2    = 8'h2c;
   // Field positions
   localparam int CTRL_CNT_LSB = 0;
   localparam int CTRL_ON      = 15;
   localparam int CTRL_DOWN    = 16;
   localparam int BASE_EXP_LSB = 0;
   localparam int BASE_LO_LSB  = 6;
   localparam int ST_PRI       = 0;
   localparam int ST_SEC       = 1;
   localparam int ST_AER       = 2;
   // Header codes
   localparam logic [7:0] FT_MWR3   = 8'h40;
   localparam logic [7:0] FT_MWR4   = 8'h60;
   localparam logic [4:0] TY_MSGADR = 5'h11;
   localparam logic [1:0] AT_UNTR   = 2'h0;

   typedef struct packed {
      logic        valid;
      logic [7:0]  fmt_type;
      logic [1:0]  at;
      logic [63:0] addr;
      logic        poison;
      logic        ecrc_err;
      logic        acs_src_fail;
      logic [3:0]  partition;
   } mci_tlp_t;

   typedef struct packed {
      logic       valid;
      logic       is_mc;
      logic [5:0] gid;
      logic       acs_err;
      mci_tlp_t   tlp;
   } mci_cls_t;
endpackage

// File: rtl/mci_classifier.sv
// Multicast ingress classifier for one switch partition, with APB regs.
// Assumes TLP headers from same-clock logic, one per cycle, no stall.
//
// Notes on behaviour
// RQ1 - At most 64 groups; capacity field writable until multicast first on.
// RQ2 - Capacity field resets to the code for 32 groups.
// RQ3 - Multicast TLPs keep their ingress partition, never cross partitions.
// RQ4 - With multicast off, nothing is classified multicast.
// RQ5 - Only posted memory writes and address-routed messages may match.
// RQ6 - Multicast TLPs keep posted ordering; pipeline is strictly in order.
// RQ7 - Regions are contiguous from the base, each two to the exponent.
// RQ8 - Base address is a full 64-bit value; base bits 5:0 are held at zero, as the exponent uses those bits of A_BASE_LO.
// RQ9 - No region exists above the enabled group count.
// RQ10 - Zero low and group bits, compare with base, mismatch is unicast.
// RQ11 - Group id is ceil(log2(count+1)) bits starting at the exponent.
// RQ12 - A group id past the enabled groups is unicast.
// RQ13 - Multicast TLPs get only the ACS source validation check.
// RQ14 - Drop-every-group bit of the group blocks the TLP.
// RQ15 - Drop-raw-address bit blocks untranslated TLPs of the group.
// RQ16 - Blocked TLPs are dropped and their credits returned.
// RQ17 - Blocked TLPs raise an AER event and log the header.
// RQ18 - Target abort flag: primary on upstream, secondary on downstream.
// RQ19 - Software sets count, exponent and base alike in every function.
// RQ20 - Software quiesces multicast before changing routing fields.
// RQ21 - Unicast TLPs pass on for ordinary routing.
// RQ22 - Poison and ECRC flags pass through unchanged for all TLPs.
// RQ23 - Multicast flag and group id leave with the header.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module mci_classifier (
   // Clock, reset, enable
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                ce,
   // APB slave
   input  wire logic [7:0]          paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Ingress header stream
   input  wire mci_pkg::mci_tlp_t   tlp_in,
   // Classified stream to routing
   output mci_pkg::mci_cls_t        cls_out,
   // Blocking events
   output logic                     credit_ret,
   output logic                     aer_mc_blocked,
   output logic                     ta_pri_flag,
   output logic                     ta_sec_flag
);
   // Register state
   logic [5:0]  cap;
   logic        cap_lock;
   logic [5:0]  cnt;
   logic        on;
   logic        down;
   logic [63:0] base;
   logic [5:0]  exp;
   logic [63:0] dall;
   logic [63:0] draw;
   logic [2:0]  st;
   logic [31:0] log0;
   logic [31:0] log1;
   logic [31:0] log2;
   logic [5:0]  next_cap;
   logic        next_cap_lock;
   logic [5:0]  next_cnt;
   logic        next_on;
   logic        next_down;
   logic [63:0] next_base;
   logic [5:0]  next_exp;
   logic [63:0] next_dall;
   logic [63:0] next_draw;
   logic [2:0]  next_st;
   logic [31:0] next_log0;
   logic [31:0] next_log1;
   logic [31:0] next_log2;
   // Bus and pipeline
   logic [31:0]        next_prdata;
   logic               next_pready;
   logic               next_pslverr;
   mci_pkg::mci_cls_t  next_cls;
   logic               next_credit;
   logic               access;
   logic               wr;
   logic [31:0]        rdata;
   logic               mapped;
   logic [5:0]         eff_cnt;
   logic               hit;
   logic [5:0]         gid;
   logic               elig;
   logic               mc;
   logic               blk;

   mci_group_match u_match (
      .addr (tlp_in.addr),
      .base (base),
      .exp  (exp),
      .cnt  (eff_cnt),
      .hit  (hit),
      .gid  (gid)
   );

   // Classification
   always_comb begin
      eff_cnt = (cnt > cap) ? cap : cnt; // [RQ1]
      elig = tlp_in.valid &&
             ((tlp_in.fmt_type == mci_pkg::FT_MWR3) ||
              (tlp_in.fmt_type == mci_pkg::FT_MWR4) ||
              (tlp_in.fmt_type[4:0] == mci_pkg::TY_MSGADR &&
               !tlp_in.fmt_type[7])); // [RQ5]
      mc  = on && elig && hit; // [RQ4] [RQ9]
      blk = mc && (dall[gid] || // [RQ14]
                   (draw[gid] && tlp_in.at == mci_pkg::AT_UNTR)); // [RQ15]
      next_cls.valid   = tlp_in.valid && !blk; // [RQ16] [RQ21]
      next_cls.is_mc   = mc && !blk; // [RQ23]
      next_cls.gid     = mc ? gid : 6'h00;
      next_cls.acs_err = mc && tlp_in.acs_src_fail; // [RQ13]
      next_cls.tlp     = tlp_in; // [RQ3] [RQ6] [RQ22]
      next_credit      = blk; // [RQ16]
   end

   // APB decode
   always_comb begin
      access = psel && penable;
      wr     = access && pready && pwrite;
      mapped = 1'b1;
      rdata  = 32'h0000_0000;
      if (paddr == mci_pkg::A_CAP) begin
         rdata[5:0] = cap;
      end else if (paddr == mci_pkg::A_CTRL) begin
         rdata[mci_pkg::CTRL_CNT_LSB +: 6] = cnt;
         rdata[mci_pkg::CTRL_ON]   = on;
         rdata[mci_pkg::CTRL_DOWN] = down;
      end else if (paddr == mci_pkg::A_BASE_LO) begin
         rdata = {base[31:6], exp};
      end else if (paddr == mci_pkg::A_BASE_HI) begin
         rdata = base[63:32];
      end else if (paddr == mci_pkg::A_DALL_LO) begin
         rdata = dall[31:0];
      end else if (paddr == mci_pkg::A_DALL_HI) begin
         rdata = dall[63:32];
      end else if (paddr == mci_pkg::A_DRAW_LO) begin
         rdata = draw[31:0];
      end else if (paddr == mci_pkg::A_DRAW_HI) begin
         rdata = draw[63:32];
      end else if (paddr == mci_pkg::A_STAT) begin
         rdata[2:0] = st;
      end else if (paddr == mci_pkg::A_LOG0) begin
         rdata = log0;
      end else if (paddr == mci_pkg::A_LOG1) begin
         rdata = log1;
      end else if (paddr == mci_pkg::A_LOG2) begin
         rdata = log2;
      end else begin
         mapped = 1'b0;
      end
      next_pready  = access && !pready;
      next_pslverr = access && !pready && !mapped;
      next_prdata  = (access && !pready && !pwrite) ? rdata : prdata;
   end

   // Register writes and event capture
   always_comb begin
      next_cap      = cap;
      next_cap_lock = cap_lock || on;
      next_cnt      = cnt;
      next_on       = on;
      next_down     = down;
      next_base     = base;
      next_exp      = exp;
      next_dall     = dall;
      next_draw     = draw;
      next_st       = st;
      next_log0     = log0;
      next_log1     = log1;
      next_log2     = log2;
      if (wr && mapped) begin
         if (paddr == mci_pkg::A_CAP) begin
            if (!cap_lock) begin
               next_cap = pwdata[5:0]; // [RQ1]
            end
         end else if (paddr == mci_pkg::A_CTRL) begin
            next_cnt  = pwdata[mci_pkg::CTRL_CNT_LSB +: 6];
            next_on   = pwdata[mci_pkg::CTRL_ON];
            next_down = pwdata[mci_pkg::CTRL_DOWN];
         end else if (paddr == mci_pkg::A_BASE_LO) begin
            next_base[31:0] = {pwdata[31:6], 6'h00}; // [RQ8]
            next_exp = pwdata[mci_pkg::BASE_EXP_LSB +: 6];
         end else if (paddr == mci_pkg::A_BASE_HI) begin
            next_base[63:32] = pwdata;
         end else if (paddr == mci_pkg::A_DALL_LO) begin
            next_dall[31:0] = pwdata;
         end else if (paddr == mci_pkg::A_DALL_HI) begin
            next_dall[63:32] = pwdata;
         end else if (paddr == mci_pkg::A_DRAW_LO) begin
            next_draw[31:0] = pwdata;
         end else if (paddr == mci_pkg::A_DRAW_HI) begin
            next_draw[63:32] = pwdata;
         end else if (paddr == mci_pkg::A_STAT) begin
            next_st = st & ~pwdata[2:0];
         end
      end
      // Set after clear so a new event wins
      if (blk) begin
         if (!st[mci_pkg::ST_AER]) begin
            next_log0 = tlp_in.addr[31:0]; // [RQ17]
            next_log1 = tlp_in.addr[63:32];
            next_log2 = {14'h0000, tlp_in.at, gid, tlp_in.fmt_type,
                         2'h0};
         end
         next_st[mci_pkg::ST_AER] = 1'b1; // [RQ17]
         if (down) begin
            next_st[mci_pkg::ST_SEC] = 1'b1; // [RQ18]
         end else begin
            next_st[mci_pkg::ST_PRI] = 1'b1; // [RQ18]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap            <= mci_pkg::CAP_RST; // [RQ2]
         cap_lock       <= 1'b0;
         cnt            <= 6'h00;
         on             <= 1'b0;
         down           <= 1'b0;
         base           <= 64'h0;
         exp            <= 6'h00;
         dall           <= 64'h0;
         draw           <= 64'h0;
         st             <= 3'h0;
         log0           <= 32'h0000_0000;
         log1           <= 32'h0000_0000;
         log2           <= 32'h0000_0000;
         prdata         <= 32'h0000_0000;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
         cls_out        <= '0;
         credit_ret     <= 1'b0;
         aer_mc_blocked <= 1'b0;
         ta_pri_flag    <= 1'b0;
         ta_sec_flag    <= 1'b0;
      end else if (ce) begin
         cap            <= next_cap;
         cap_lock       <= next_cap_lock;
         cnt            <= next_cnt;
         on             <= next_on;
         down           <= next_down;
         base           <= next_base;
         exp            <= next_exp;
         dall           <= next_dall;
         draw           <= next_draw;
         st             <= next_st;
         log0           <= next_log0;
         log1           <= next_log1;
         log2           <= next_log2;
         prdata         <= next_prdata;
         pready         <= next_pready;
         pslverr        <= next_pslverr;
         cls_out        <= next_cls;
         credit_ret     <= next_credit;
         aer_mc_blocked <= next_credit;
         ta_pri_flag    <= next_st[mci_pkg::ST_PRI];
         ta_sec_flag    <= next_st[mci_pkg::ST_SEC];
      end
   end

   // Checks
   chk_cap_reset: assert property ( // [RQ2]
      @(posedge pclk) $rose(presetn) |-> cap == mci_pkg::CAP_RST)
      else $error("capacity not at reset value");

   chk_off_no_mc: assert property ( // [RQ4]
      @(posedge pclk) disable iff (!presetn)
      ce && tlp_in.valid && !on |=> cls_out.valid && !cls_out.is_mc)
      else $error("multicast seen while off");

   chk_type_gate: assert property ( // [RQ5]
      @(posedge pclk) disable iff (!presetn)
      ce && tlp_in.valid && !elig |=> !cls_out.is_mc)
      else $error("ineligible type classified multicast");

   chk_gid_bound: assert property ( // [RQ12]
      @(posedge pclk) disable iff (!presetn)
      ce && mc |=> cls_out.gid <= $past(eff_cnt))
      else $error("group id beyond enabled groups");

   chk_mc_out: assert property ( // [RQ23]
      @(posedge pclk) disable iff (!presetn)
      ce && mc && !blk |=> cls_out.is_mc && cls_out.gid == $past(gid))
      else $error("multicast flag or group id lost");

   chk_same_part: assert property ( // [RQ3]
      @(posedge pclk) disable iff (!presetn)
      ce && tlp_in.valid && !blk
      |=> cls_out.tlp.partition == $past(tlp_in.partition))
      else $error("partition changed");

   chk_blk_drop: assert property ( // [RQ16]
      @(posedge pclk) disable iff (!presetn)
      ce && blk |=> credit_ret && aer_mc_blocked && !cls_out.valid)
      else $error("blocked TLP not dropped");

   chk_log_capture: assert property ( // [RQ17]
      @(posedge pclk) disable iff (!presetn)
      ce && blk && !st[mci_pkg::ST_AER]
      |=> log0 == $past(tlp_in.addr[31:0]) && st[mci_pkg::ST_AER])
      else $error("header not logged");

   chk_ta_side: assert property ( // [RQ18]
      @(posedge pclk) disable iff (!presetn)
      ce && blk |=> ($past(down) ? ta_sec_flag : ta_pri_flag))
      else $error("target abort flag on wrong side");

   chk_apb_ready: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && psel && penable && !pready |=> pready)
      else $error("apb answer late");

   chk_all_block: assert property ( // [RQ14]
      @(posedge pclk) disable iff (!presetn)
      ce && mc && dall[gid] |=> credit_ret && !cls_out.valid)
      else $error("drop-every-group bit ignored");

   chk_raw_block: assert property ( // [RQ15]
      @(posedge pclk) disable iff (!presetn)
      ce && mc && draw[gid] && tlp_in.at == mci_pkg::AT_UNTR
      |=> credit_ret && !cls_out.valid)
      else $error("untranslated TLP not blocked");

   chk_acs_gate: assert property ( // [RQ13]
      @(posedge pclk) disable iff (!presetn)
      ce && !mc |=> !cls_out.acs_err)
      else $error("ACS error flagged on non-multicast TLP");

   chk_flag_pass: assert property ( // [RQ22]
      @(posedge pclk) disable iff (!presetn)
      ce && tlp_in.valid
      |=> cls_out.tlp.poison == $past(tlp_in.poison) &&
          cls_out.tlp.ecrc_err == $past(tlp_in.ecrc_err))
      else $error("poison or ECRC flag altered");

   chk_cap_lock: assert property ( // [RQ1]
      @(posedge pclk) disable iff (!presetn)
      ce && cap_lock |=> cap == $past(cap))
      else $error("capacity changed after lock");

   chk_ce_freeze: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ce |=> $stable(cls_out) && $stable(pready) && $stable(st))
      else $error("state moved while clock enable low");
endmodule // mci_classifier

// File: rtl/mci_group_match.sv
// Address to group match: base compare and group identifier extraction.
// Assumes settled register values; purely combinational.
`timescale 1ns/1ps
module mci_group_match (
   // Header address
   input  wire logic [63:0] addr,
   // Region setup
   input  wire logic [63:0] base,
   input  wire logic [5:0]  exp,
   input  wire logic [5:0]  cnt,
   // Result
   output logic             hit,
   output logic [5:0]       gid
);
   logic [6:0]  cnt_p1;
   logic [2:0]  nb;
   logic [63:0] low_m;
   logic [63:0] id_m;
   logic [63:0] raw;
   logic        base_eq;

   always_comb begin
      cnt_p1 = {1'b0, cnt} + 7'h01;
      nb = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (cnt_p1 > (7'h01 << i)) begin // [RQ11]
            nb = 3'(i + 1);
         end
      end
      low_m   = (64'h1 << exp) - 64'h1; // [RQ7]
      id_m    = ((64'h1 << nb) - 64'h1) << exp;
      base_eq = (addr & ~(low_m | id_m)) == base; // [RQ8] [RQ10]
      raw     = (addr & id_m) >> exp; // [RQ11]
      gid     = raw[5:0];
      hit     = base_eq && (gid <= cnt); // [RQ9] [RQ12]
   end
endmodule // mci_group_match

// File: tb/mci_classifier_tb.sv
// Self-checking bench of the multicast ingress classifier.
// Assumes the package and the partner model are compiled first.
`timescale 1ns/1ps
module mci_classifier_tb;
   logic              pclk, presetn, ce, psel, penable, pwrite, pready;
   logic              pslverr, credit_ret, aer_mc_blocked;
   logic              ta_pri_flag, ta_sec_flag, on, e, sticky;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rnd, q, lg2;
   logic [63:0]       base, dall, draw, logged;
   logic [5:0]        ix, cnt;
   mci_pkg::mci_tlp_t req, tlp_in;
   mci_pkg::mci_cls_t cls_out;
   int                n_fail, check_count, nblk;
   int                cyc = 0;
   logic [7:0]        fmts [8] = '{8'h40, 8'h60, 8'h31, 8'h71,
                                   8'h00, 8'h20, 8'h44, 8'h30};

   mci_tlp_src mci_tlp_src_inst (.pclk(pclk), .presetn(presetn),
      .req(req), .tlp_in(tlp_in));
   mci_classifier mci_classifier_inst (.pclk(pclk), .presetn(presetn),
      .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tlp_in(tlp_in), .cls_out(cls_out),
      .credit_ret(credit_ret), .aer_mc_blocked(aer_mc_blocked),
      .ta_pri_flag(ta_pri_flag), .ta_sec_flag(ta_sec_flag));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Expected {blocked, multicast, group id} of one header
   function automatic logic [7:0] ref_cls(input mci_pkg::mci_tlp_t t);
      int          nb;
      logic [63:0] m;
      logic [5:0]  g;
      logic        el, mc;
      nb = $clog2(int'(cnt) + 1);
      m = ~((64'h1 << (int'(ix) + nb)) - 64'h1);
      g = 6'((t.addr >> ix) & ((64'h1 << nb) - 64'h1));
      el = t.fmt_type == 8'h40 || t.fmt_type == 8'h60 ||
           (t.fmt_type[4:0] == 5'h11 && !t.fmt_type[7]);
      mc = t.valid && on && el && (t.addr & m) == base && g <= cnt;
      return {mc && (dall[g] || (draw[g] && t.at == 2'h0)), mc, g & {6{mc}}};
   endfunction

   task automatic cmp_reg(input string nm, input logic [31:0] ex, got);
      check_count++;
      if (got !== ex) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic cmp_cls(input mci_pkg::mci_cls_t ex, got);
      check_count++;
      if (ex.valid ? got !== ex : got.valid !== 1'b0) begin
         n_fail++;
         $display("CHECK FAILED cls_out expected %h seen %h", ex, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      cmp_reg("register read", ex, q);
   endtask

   task automatic ctl(input logic down);
      apb(1'b1, mci_pkg::A_CTRL, {15'h0, down, on, 9'h0, cnt});
   endtask

   // Back-to-back headers; each result is checked the cycle after capture
   task automatic run(input int n);
      logic [7:0]        r, pr;
      mci_pkg::mci_tlp_t t;
      mci_pkg::mci_cls_t x;
      logic [5:0]        g;
      pr = 8'h0;
      x = '0;
      for (int i = 0; i <= n; i++) begin
         rnd = lfsr(rnd);
         t = '0;
         t.valid = i < n && rnd[31:30] != 2'h0;
         t.fmt_type = fmts[rnd[29:27]];
         t.at = rnd[26:25];
         t.addr = base + 64'(rnd[16:0]);
         t.addr[40] = rnd[24] & rnd[23];
         {t.poison, t.ecrc_err, t.acs_src_fail} = rnd[22:20];
         t.partition = rnd[19:16];
         // Groups 0, last, one past last, then the two blocked groups
         if (i < 5) begin
            t.valid = 1'b1;
            t.fmt_type = 8'h40;
            t.at = 2'h0;
            g = i == 3 ? 6'h2 : i == 4 ? 6'h4 : 6'h0;
            if (i == 1 || i == 2)
               g = cnt + 6'(i - 1);
            t.addr = base + (64'(g) << ix);
         end
         @(posedge pclk);
         req <= t;
         #1;
         if (i > 0) begin
            cmp_cls(x, cls_out);
            cmp_reg("credit_ret", 32'(pr[7]), 32'(credit_ret));
            cmp_reg("aer", 32'(pr[7]), 32'(aer_mc_blocked));
         end
         r = ref_cls(t);
         x.valid = t.valid && !r[7];
         x.is_mc = r[6];
         x.gid = r[5:0];
         x.acs_err = r[6] && t.acs_src_fail;
         x.tlp = t;
         if (r[7] && !sticky) begin
            logged = t.addr;
            lg2 = {14'h0, t.at, r[5:0], t.fmt_type, 2'h0};
         end
         sticky |= r[7];
         nblk += int'(r[7]);
         pr = r;
      end
   endtask

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      req = '0;
      rnd = 32'h2d;
      n_fail = 0;
      check_count = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(mci_pkg::A_CAP, 32'h1f);
      apb(1'b1, mci_pkg::A_CAP, 32'h3f);
      rd(mci_pkg::A_CAP, 32'h3f);
      apb(1'b0, 8'h30, 32'h0);
      cmp_reg("pslverr", 32'h1, 32'(e));
      cmp_reg("unmapped read", 32'h0, q);
      // Base above 4 GB, 4 KB regions, six groups, multicast off
      ix = 6'd12;
      cnt = 6'd5;
      on = 1'b0;
      base = 64'h0000_0012_4000_0000;
      dall = 64'h4;
      draw = 64'h10;
      ctl(1'b0);
      apb(1'b1, mci_pkg::A_BASE_LO, {base[31:6], ix});
      apb(1'b1, mci_pkg::A_BASE_HI, base[63:32]);
      apb(1'b1, mci_pkg::A_DALL_LO, dall[31:0]);
      apb(1'b1, mci_pkg::A_DALL_HI, dall[63:32]);
      apb(1'b1, mci_pkg::A_DRAW_LO, draw[31:0]);
      apb(1'b1, mci_pkg::A_DRAW_HI, draw[63:32]);
      sticky = 1'b0;
      nblk = 0;
      run(40);
      on = 1'b1;
      ctl(1'b0);
      run(300);
      cmp_reg("ta_pri", 32'(nblk > 0), 32'(ta_pri_flag));
      rd(mci_pkg::A_STAT, nblk > 0 ? 32'h5 : 32'h0);
      rd(mci_pkg::A_LOG0, logged[31:0]);
      apb(1'b1, mci_pkg::A_CAP, 32'h0);
      rd(mci_pkg::A_CAP, 32'h3f);
      apb(1'b1, mci_pkg::A_STAT, 32'h7);
      sticky = 1'b0;
      nblk = 0;
      ctl(1'b1);
      run(200);
      cmp_reg("ta_sec", 32'(nblk > 0), 32'(ta_sec_flag));
      rd(mci_pkg::A_STAT, nblk > 0 ? 32'h6 : 32'h0);
      rd(mci_pkg::A_LOG1, logged[63:32]);
      rd(mci_pkg::A_LOG2, lg2);
      // Reset again in mid-run, then stall one read with ce low
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(mci_pkg::A_CAP, 32'h1f);
      rd(mci_pkg::A_STAT, 32'h0);
      ce <= 1'b0;
      fork
         rd(mci_pkg::A_CAP, 32'h1f);
         begin
            repeat (6) @(posedge pclk);
            ce <= 1'b1;
         end
      join
      tally_and_finish();
   end
endmodule // mci_classifier_tb

// File: tb/mci_tlp_src.sv
// Link partner model: presents TLP headers to the classifier ingress.
// Assumes the bench sets the next header just after each clock edge.
`timescale 1ns/1ps
module mci_tlp_src (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Header asked for by the bench
   input  wire mci_pkg::mci_tlp_t req,
   // Header on the ingress link
   output mci_pkg::mci_tlp_t      tlp_in
);
   mci_pkg::mci_tlp_t last;

   // Idle cycles show the inverse of the previous cycle's value, so every second idle cycle repeats the last header
   always_comb begin
      tlp_in = req.valid ? req : ~last;
      tlp_in.valid = req.valid;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         last <= '0;
      else
         last <= tlp_in;
   end
endmodule // mci_tlp_src
